/* File: src/insn_decode_pkg.sv */
// shared constants and types for the instruction decoder
package insn_decode_pkg;

	// ----------------------------------------
	// word and field layout
	// ----------------------------------------
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int IDX_W = 7;
	localparam int LIT_W = 11;
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int IDX_HI = 6;
	localparam int BPOS_HI = 9;
	localparam int BPOS_LO = 7;
	localparam int LIT_HI = 10;
	localparam int SEL_STEP_BIT = 2;
	localparam int SEL_OFF_BIT = 6;
	localparam int STEP_HI = 1;

	// ----------------------------------------
	// fixed values
	// ----------------------------------------
	localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
	localparam logic [IDX_W-1:0] IND0_IDX = 7'h00;
	localparam logic [IDX_W-1:0] IND1_IDX = 7'h01;
	localparam logic [IDX_W-1:0] REG_IDX_MAX = 7'h7F;
	localparam int PHASES = 4;
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam logic [1:0] PH_READ = 2'h1;
	localparam logic [1:0] PH_CALC = 2'h2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [1:0] STEP_PRE_INC = 2'h0;
	localparam logic [1:0] STEP_PRE_DEC = 2'h1;
	localparam logic [1:0] STEP_POST_INC = 2'h2;
	localparam logic [1:0] STEP_POST_DEC = 2'h3;
	localparam logic [1:0] CYC_ONE = 2'h1;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LIT} insn_class_t;
	typedef enum logic [1:0] {WR_NONE, WR_FILE, WR_ACC, WR_BY_D} wr_kind_t;
	typedef enum logic [1:0] {ST_EXEC, ST_EXTRA, ST_FLUSH} seq_state_t;
	typedef struct packed {
		insn_class_t cls;
		wr_kind_t wr;
		logic file_op;
		logic two;
		logic step_op;
		logic off_op;
	} dec_t;

endpackage

/* File: src/phase_gen.sv */
// four-phase sequencer inside one instruction cycle
`timescale 1ns/100ps
`default_nettype none
module phase_gen
	import insn_decode_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// phase
	output logic [1:0] phase_out,
	output logic first_out,
	output logic last_out
);

	logic [1:0] phase_r;

	// ----------------------------------------
	// phase counter
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			phase_r <= PH_FIRST;
		end else begin
			phase_r <= 2'(phase_r + 2'h1);
		end
	end

	assign phase_out = phase_r;
	assign first_out = (phase_r == PH_FIRST);
	assign last_out = (phase_r == 2'(PHASES - 1));

endmodule
`default_nettype wire

/* File: src/field_split.sv */
// operand field extraction from the held instruction word
`timescale 1ns/100ps
`default_nettype none
module field_split
	import insn_decode_pkg::*;
(
	// word
	input wire logic [WORD_W-1:0] word_in,
	// fields
	output logic [OPC_HI-OPC_LO:0] opcode_out,
	output logic [IDX_W-1:0] reg_index_out,
	output logic [BPOS_HI-BPOS_LO:0] bit_pos_out,
	output logic dest_out,
	output logic [LIT_W-1:0] literal_out,
	output logic [STEP_HI:0] step_out,
	output logic sel_step_out,
	output logic sel_off_out
);

	// ----------------------------------------
	// field wiring
	// ----------------------------------------
	assign opcode_out = word_in[OPC_HI:OPC_LO];
	assign reg_index_out = word_in[IDX_HI:0];
	assign bit_pos_out = word_in[BPOS_HI:BPOS_LO];
	assign dest_out = word_in[DEST_BIT];
	assign literal_out = word_in[LIT_HI:0];
	assign step_out = word_in[STEP_HI:0];
	assign sel_step_out = word_in[SEL_STEP_BIT];
	assign sel_off_out = word_in[SEL_OFF_BIT];

endmodule
`default_nettype wire

/* File: src/insn_decode_cycle_timing.sv */
// instruction decoder with cycle timing and read-modify-write strobes
//
// What this block does
// - decode from one 14-bit word
// - sort into byte, bit, literal classes
// - one instruction cycle by default
// - calls take two cycles
// - returns take two cycles
// - jumps and skips take two cycles
// - indirect access to program memory adds cycle
// - four clocks per instruction cycle
// - file operand: read, modify, then store
// - result goes where instruction or target says
// - target 0 accumulator, 1 file register
// - register index spans 0x00 to 0x7F
// - bit position picks one of eight
// - ignored bits never change decoding
// - pointer select picks pointer 0 or 1
// - step field picks pre/post inc/dec
// - literal field carries data or target
`timescale 1ns/100ps
`default_nettype none
module insn_decode_cycle_timing
	import insn_decode_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// fetch path
	input wire logic [WORD_W-1:0] insn_word_in,
	input wire logic insn_valid_in,
	output logic insn_taken_out,
	// pointer targets, high when pointing at program memory
	input wire logic [1:0] ptr_prog_in,
	// register file and accumulator data
	input wire logic [DATA_W-1:0] file_rd_data_in,
	input wire logic [DATA_W-1:0] alu_result_in,
	// decoded fields
	output logic [1:0] class_out,
	output logic [OPC_HI-OPC_LO:0] opcode_out,
	output logic [IDX_W-1:0] reg_index_out,
	output logic [BPOS_HI-BPOS_LO:0] bit_pos_out,
	output logic [LIT_W-1:0] literal_out,
	output logic ptr_sel_out,
	output logic [1:0] cycles_out,
	// sequencing
	output logic [1:0] phase_out,
	output logic cycle_start_out,
	output logic flush_out,
	output logic idle_cycle_out,
	output logic extra_cycle_out,
	// read-modify-write strobes
	output logic file_rd_out,
	output logic [DATA_W-1:0] operand_out,
	output logic file_wr_out,
	output logic acc_wr_out,
	output logic [DATA_W-1:0] wr_data_out,
	// pointer stepping
	output logic ptr_inc_out,
	output logic ptr_dec_out
);

	// ----------------------------------------
	// opcode table
	// ----------------------------------------
	function automatic dec_t decode_word(input logic [WORD_W-1:0] w);
		dec_t d;
		d.cls = CLS_LIT;
		d.wr = WR_NONE;
		d.file_op = 1'b0;
		d.two = 1'b0;
		d.step_op = 1'b0;
		d.off_op = 1'b0;
		// don't-care bits are wildcards, never compared
		casez (w)
			14'b00_0000_0000_1000,
			14'b00_0000_0000_1001: begin
				d.two = 1'b1;
			end
			14'b00_0000_0000_1010: begin
				d.two = 1'b1;
			end
			14'b00_0000_0000_1011: begin
				d.two = 1'b1;
			end
			14'b00_0000_0001_0???: begin
				d.step_op = 1'b1;
				d.wr = WR_ACC;
			end
			14'b00_0000_0001_1???: begin
				d.step_op = 1'b1;
			end
			14'b00_0000_1???_????,
			14'b00_0001_1???_????: begin
				d.cls = CLS_BYTE;
				d.file_op = 1'b1;
				d.wr = WR_FILE;
			end
			14'b00_0000_????_????: begin
				d.cls = CLS_LIT;
			end
			14'b00_0001_0000_00??: begin
				d.cls = CLS_BYTE;
				d.wr = WR_ACC;
			end
			14'b00_1011_????_????,
			14'b00_1111_????_????: begin
				d.cls = CLS_BYTE;
				d.file_op = 1'b1;
				d.wr = WR_BY_D;
				d.two = 1'b1;
			end
			14'b00_????_????_????: begin
				d.cls = CLS_BYTE;
				d.file_op = 1'b1;
				d.wr = WR_BY_D;
			end
			14'b01_0???_????_????: begin
				d.cls = CLS_BIT;
				d.file_op = 1'b1;
				d.wr = WR_FILE;
			end
			14'b01_1???_????_????: begin
				d.cls = CLS_BIT;
				d.file_op = 1'b1;
				d.two = 1'b1;
			end
			14'b10_0???_????_????: begin
				d.two = 1'b1;
			end
			14'b10_1???_????_????,
			14'b11_001?_????_????: begin
				d.two = 1'b1;
			end
			14'b11_0100_????_????: begin
				d.wr = WR_ACC;
				d.two = 1'b1;
			end
			14'b11_01??_????_????,
			14'b11_1011_????_????,
			14'b11_1101_????_????: begin
				d.cls = CLS_BYTE;
				d.file_op = 1'b1;
				d.wr = WR_BY_D;
			end
			14'b11_1111_????_????: begin
				d.off_op = 1'b1;
				d.wr = w[DEST_BIT] ? WR_NONE : WR_ACC;
			end
			default: begin
				d.wr = WR_ACC;
			end
		endcase
		return d;
	endfunction

	// pointer used by a word, and whether it reaches an indirect window
	function automatic logic [1:0] ptr_use(input logic [WORD_W-1:0] w,
			input dec_t d);
		logic hit;
		logic sel;
		hit = 1'b0;
		sel = w[0];
		if (d.step_op) begin
			hit = 1'b1;
			sel = w[SEL_STEP_BIT];
		end else if (d.off_op) begin
			hit = 1'b1;
			sel = w[SEL_OFF_BIT];
		end else if (d.file_op) begin
			hit = (w[IDX_HI:0] == IND0_IDX) || (w[IDX_HI:0] == IND1_IDX);
		end
		return {hit, sel};
	endfunction

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic [1:0] phase;
	logic ph_first;
	logic ph_last;
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [WORD_W-1:0] word_r;
	logic [WORD_W-1:0] word_nxt;
	dec_t dec_r;
	dec_t dec_nxt;
	logic extra_r;
	logic [1:0] cycles_r;
	logic [1:0] use_nxt;
	logic extra_nxt;
	logic [DATA_W-1:0] operand_r;
	logic [DATA_W-1:0] wr_data_r;
	logic dest_d;
	logic [STEP_HI:0] step;
	logic sel_step;
	logic sel_off;
	logic exec;
	logic write_here;
	logic step_now;
	logic take;

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	phase_gen u_phase (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.phase_out(phase),
		.first_out(ph_first),
		.last_out(ph_last)
	);

	field_split u_fields (
		.word_in(word_r),
		.opcode_out(opcode_out),
		.reg_index_out(reg_index_out),
		.bit_pos_out(bit_pos_out),
		.dest_out(dest_d),
		.literal_out(literal_out),
		.step_out(step),
		.sel_step_out(sel_step),
		.sel_off_out(sel_off)
	);

	// ----------------------------------------
	// cycle sequencing
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (ph_last) begin
			case (state_r)
				ST_EXEC: begin
					if (extra_r) begin
						state_nxt = ST_EXTRA;
					end else if (dec_r.two) begin
						state_nxt = ST_FLUSH;
					end else begin
						state_nxt = ST_EXEC;
					end
				end
				ST_EXTRA: begin
					state_nxt = dec_r.two ? ST_FLUSH : ST_EXEC;
				end
				ST_FLUSH: begin
					state_nxt = ST_EXEC;
				end
				default: begin
					state_nxt = ST_FLUSH;
				end
			endcase
		end
	end

	assign take = ph_last && (state_nxt == ST_EXEC);
	assign word_nxt = insn_valid_in ? insn_word_in : NOP_WORD;
	assign dec_nxt = decode_word(word_nxt);
	assign use_nxt = ptr_use(word_nxt, dec_nxt);
	assign extra_nxt = use_nxt[1] && ptr_prog_in[use_nxt[0]];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_r <= ST_FLUSH;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			word_r <= NOP_WORD;
			dec_r <= decode_word(NOP_WORD);
			extra_r <= 1'b0;
			cycles_r <= CYC_ONE;
		end else if (take) begin
			word_r <= word_nxt;
			dec_r <= dec_nxt;
			extra_r <= extra_nxt;
			cycles_r <= 2'(CYC_ONE + {1'b0, dec_nxt.two} + {1'b0, extra_nxt});
		end
	end

	// ----------------------------------------
	// read-modify-write datapath
	// ----------------------------------------
	assign exec = (state_r == ST_EXEC);
	assign write_here = exec && (phase == PH_LAST);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			operand_r <= '0;
		end else if (file_rd_out) begin
			operand_r <= file_rd_data_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wr_data_r <= '0;
		end else if (exec && (phase == PH_CALC)) begin
			wr_data_r <= alu_result_in;
		end
	end

	// read even when the instruction only writes the register
	assign file_rd_out = exec && dec_r.file_op && (phase == PH_READ);
	assign file_wr_out = write_here && ((dec_r.wr == WR_FILE) ||
		((dec_r.wr == WR_BY_D) && dest_d));
	assign acc_wr_out = write_here && ((dec_r.wr == WR_ACC) ||
		((dec_r.wr == WR_BY_D) && !dest_d));

	// ----------------------------------------
	// pointer stepping
	// ----------------------------------------
	assign step_now = exec && dec_r.step_op &&
		((ph_first && !step[1]) || (ph_last && step[1]));
	assign ptr_inc_out = step_now && !step[0];
	assign ptr_dec_out = step_now && step[0];
	assign ptr_sel_out = dec_r.step_op ? sel_step :
		(dec_r.off_op ? sel_off : word_r[0]);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign insn_taken_out = take;
	assign class_out = dec_r.cls;
	assign cycles_out = cycles_r;
	assign phase_out = phase;
	assign cycle_start_out = ph_first;
	assign flush_out = ph_last && (state_nxt == ST_FLUSH);
	assign idle_cycle_out = (state_r == ST_FLUSH);
	assign extra_cycle_out = (state_r == ST_EXTRA);
	assign operand_out = operand_r;
	assign wr_data_out = wr_data_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [3:0] since_take_r;
	logic seen_take_r;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			since_take_r <= 4'h0;
			seen_take_r <= 1'b0;
		end else begin
			since_take_r <= take ? 4'h1 : 4'(since_take_r + 4'h1);
			seen_take_r <= seen_take_r | take;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	AST_CYCLE_FOUR: assert property (
		cycle_start_out |=> !cycle_start_out [*3] ##1 cycle_start_out)
		else $error("instruction cycle is not four clocks");

	AST_INSN_LENGTH: assert property (
		insn_taken_out && seen_take_r |-> since_take_r == {cycles_r, 2'b00})
		else $error("instruction length differs from cycle count");

	AST_CALL_TWO: assert property (
		insn_taken_out && insn_valid_in && (insn_word_in[13:11] == 3'b100 ||
		insn_word_in == 14'h000A) |=> cycles_r >= 2'h2)
		else $error("call shorter than two cycles");

	AST_RETURN_TWO: assert property (
		insn_taken_out && insn_valid_in && (insn_word_in[13:8] == 6'h34 ||
		insn_word_in == 14'h0008 || insn_word_in == 14'h0009)
		|=> cycles_r >= 2'h2)
		else $error("return shorter than two cycles");

	AST_JUMP_FLUSH: assert property (
		insn_taken_out && insn_valid_in && insn_word_in[13:11] == 3'b101
		|-> ##4 flush_out ##1 idle_cycle_out [*4])
		else $error("absolute jump did not flush and idle");

	AST_INDIRECT_EXTRA: assert property (
		insn_taken_out && extra_nxt |-> ##5 extra_cycle_out [*4])
		else $error("indirect program access lacks extra cycle");

	AST_READ_BEFORE_WRITE: assert property (
		file_wr_out && dec_r.file_op |-> $past(file_rd_out, 2))
		else $error("file write without earlier read");

	AST_DEST_SELECT: assert property (
		file_wr_out && dec_r.wr == WR_BY_D |-> word_r[DEST_BIT] && !acc_wr_out)
		else $error("file written while target selects accumulator");

	AST_CLASS_BIT: assert property (
		class_out == CLS_BIT |-> word_r[13:12] == 2'b01)
		else $error("bit class on a non bit word");

	AST_PRE_STEP: assert property (
		ptr_inc_out && phase_out == PH_FIRST |-> step == STEP_PRE_INC)
		else $error("pre step with a post step code");

	COV_TWO_CYCLE: cover property (insn_taken_out && dec_nxt.two);
	COV_EXTRA: cover property (extra_cycle_out && cycle_start_out);
	COV_FILE_WRITE: cover property (file_wr_out);
	COV_ACC_WRITE: cover property (acc_wr_out && dec_r.wr == WR_BY_D);

endmodule
`default_nettype wire

/* File: tb/fetch_regfile_model.sv */
// fetch path and register file model facing the decoder
`timescale 1ns/100ps
`default_nettype none
module fetch_regfile_model
	import insn_decode_pkg::*;
(
	// clock
	input wire logic clock_in,
	// fetch side
	input wire logic [WORD_W-1:0] prog_word_in,
	input wire logic fetch_ok_in,
	output logic [WORD_W-1:0] insn_word_out,
	output logic insn_valid_out,
	// register file side
	input wire logic [IDX_W-1:0] reg_index_in,
	input wire logic file_rd_in,
	input wire logic file_wr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic [DATA_W-1:0] operand_in,
	output logic [DATA_W-1:0] file_rd_data_out,
	output logic [DATA_W-1:0] alu_result_out
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [DATA_W-1:0] regs_r [0:127];
	initial begin
		for (int i = 0; i < 128; i++) begin
			regs_r[i] = DATA_W'(i) ^ 8'hA5;
		end
	end
	// ----------------------------------------
	// answers
	// ----------------------------------------
	assign insn_word_out = prog_word_in;
	assign insn_valid_out = fetch_ok_in;
	// released read bus shows inverted data
	assign file_rd_data_out = file_rd_in ? regs_r[reg_index_in] :
		~regs_r[reg_index_in];
	assign alu_result_out = operand_in + 8'h01;
	// indirect windows hold no storage
	always @(posedge clock_in) begin
		if (file_wr_in && reg_index_in > IND1_IDX) begin
			regs_r[reg_index_in] <= wr_data_in;
		end
	end
endmodule
`default_nettype wire

/* File: tb/insn_decode_cycle_timing_test.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module insn_decode_cycle_timing_test
	import insn_decode_pkg::*;
();
	// ----------------------------------------
	// control word encodings, plain defaults
	// ----------------------------------------
	localparam logic [13:0] OP_SKIP_CLR = 14'h1800;
	localparam logic [13:0] OP_SKIP_SET = 14'h1C00;
	localparam logic [13:0] OP_DEC_SKIP = 14'h0B00;
	localparam logic [13:0] OP_INC_SKIP = 14'h0F00;
	localparam logic [13:0] OP_CALL = 14'h2000;
	localparam logic [13:0] OP_ABS_JUMP = 14'h2800;
	localparam logic [13:0] OP_RET_LIT = 14'h3400;
	localparam logic [13:0] OP_REL_JUMP = 14'h3200;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_RET_IRQ = 14'h0009;
	localparam logic [13:0] OP_CALL_ACC = 14'h000A;
	localparam logic [13:0] OP_JUMP_ACC = 14'h000B;
	localparam logic [13:0] OP_PTR_STEP = 14'h0010;
	typedef struct packed {
		logic [13:0] w;
		logic [1:0] p;
		logic v;
		logic f;
		logic e;
		logic [1:0] rd;
		logic [1:0] fw;
		logic [1:0] aw;
		logic [1:0] cls;
	} row_t;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clock_in, rst_in, fetch_ok, insn_valid;
	logic [WORD_W-1:0] prog_word, insn_word;
	logic [1:0] ptr_prog, cls, cycles, phase, last_ph;
	logic [DATA_W-1:0] rd_data, alu_res, operand, wr_data;
	logic insn_taken, ptr_sel, cyc_start, flush, idle, extra;
	logic file_rd, file_wr, acc_wr, ptr_inc, ptr_dec, last_inc, last_dec;
	logic [5:0] opcode;
	logic [IDX_W-1:0] reg_index;
	logic [2:0] bit_pos;
	logic [LIT_W-1:0] literal;
	int n_errors, total_checks, tk;
	row_t rows [0:23];
	insn_decode_cycle_timing dut_u (
		.clock_in(clock_in), .rst_in(rst_in),
		.insn_word_in(insn_word), .insn_valid_in(insn_valid),
		.insn_taken_out(insn_taken), .ptr_prog_in(ptr_prog),
		.file_rd_data_in(rd_data), .alu_result_in(alu_res),
		.class_out(cls), .opcode_out(opcode), .reg_index_out(reg_index),
		.bit_pos_out(bit_pos), .literal_out(literal), .ptr_sel_out(ptr_sel),
		.cycles_out(cycles), .phase_out(phase), .cycle_start_out(cyc_start),
		.flush_out(flush), .idle_cycle_out(idle), .extra_cycle_out(extra),
		.file_rd_out(file_rd), .operand_out(operand), .file_wr_out(file_wr),
		.acc_wr_out(acc_wr), .wr_data_out(wr_data),
		.ptr_inc_out(ptr_inc), .ptr_dec_out(ptr_dec));
	fetch_regfile_model pm_u (
		.clock_in(clock_in), .prog_word_in(prog_word), .fetch_ok_in(fetch_ok),
		.insn_word_out(insn_word), .insn_valid_out(insn_valid),
		.reg_index_in(reg_index), .file_rd_in(file_rd), .file_wr_in(file_wr),
		.wr_data_in(wr_data), .operand_in(operand),
		.file_rd_data_out(rd_data), .alu_result_out(alu_res));
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task end_sim();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task wait_take();
		tk = 0;
		do begin
			@(negedge clock_in);
			tk++;
		end while (insn_taken !== 1'b1 && tk < 40);
		chk(insn_taken === 1'b1, "no take");
	endtask
	task do_reset();
		@(posedge clock_in);
		#1;
		rst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		#1;
		chk(idle === 1'b1 && phase === PH_FIRST && cycles === CYC_ONE, "reset state");
		chk({file_rd, file_wr, acc_wr, flush} === 4'h0, "reset strobes");
		chk(operand === 8'h00 && wr_data === 8'h00, "reset data");
		rst_in = 1'b0;
		wait_take();
		chk(tk === 4, "first take");
		$display("reset test done");
	endtask
	task automatic run_word(input row_t r);
		logic [WORD_W-1:0] ew;
		logic [DATA_W-1:0] exp_rd;
		int n = 0, ni = 0, ne = 0, nf = 0, nr = 0, nw = 0, na = 0, ri = 0, wi = 0;
		@(posedge clock_in);
		#1;
		prog_word = r.w;
		fetch_ok = r.v;
		ptr_prog = r.p;
		ew = r.v ? r.w : NOP_WORD;
		exp_rd = {1'b0, ew[6:0]} ^ 8'hA5;
		last_inc = 1'b0;
		last_dec = 1'b0;
		wait_take();
		@(posedge clock_in);
		#1;
		prog_word = NOP_WORD;
		fetch_ok = 1'b1;
		ptr_prog = 2'h0;
		chk(opcode === ew[13:8] && reg_index === ew[6:0], "fields");
		chk(bit_pos === ew[9:7] && literal === ew[10:0], "bit, literal");
		if (r.cls != 2'h3) chk(cls === r.cls, "class");
		if (r.p != 2'h0) chk(ptr_sel === ew[0], "pointer select");
		chk(cycles === 2'(1 + r.f + r.e), "cycle field");
		do begin
			@(negedge clock_in);
			n++;
			chk(cyc_start === (phase === PH_FIRST), "phase");
			if (idle === 1'b1) ni++;
			if (extra === 1'b1) ne++;
			if (flush === 1'b1) nf++;
			if (file_wr === 1'b1) nw++;
			if (acc_wr === 1'b1) na++;
			if (file_rd === 1'b1) begin
				nr++;
				ri = n;
			end
			if ((file_wr | acc_wr) === 1'b1) begin
				wi = n;
				if (r.rd == 2'h1 && ew[6:1] != 6'h00) chk(operand === exp_rd && wr_data === exp_rd + 8'h01, "rmw data");
			end
			if ((ptr_inc | ptr_dec) === 1'b1) begin
				last_ph = phase;
				last_inc = ptr_inc;
				last_dec = ptr_dec;
			end
		end while (insn_taken !== 1'b1 && n < 20);
		chk(n === 4 * (1 + r.f + r.e), "cycle count");
		chk(ni === 4 * r.f && nf === r.f, "idle cycle");
		chk(ne === 4 * r.e, "extra cycle");
		if (r.rd != 2'h2) chk(nr === r.rd, "read count");
		if (r.fw != 2'h2) chk(nw === r.fw, "file write");
		if (r.aw != 2'h2) chk(na === r.aw, "acc write");
		if (r.rd == 2'h1 && nw + na > 0) chk(wi - ri === 2, "read before write");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		#(4000 * 100);
		n_errors++;
		$display("unexpected at %0t: watchdog", $time);
		end_sim();
	end
	initial begin
		rst_in = 1'b1;
		prog_word = NOP_WORD;
		fetch_ok = 1'b1;
		ptr_prog = 2'h0;
		n_errors = 0;
		total_checks = 0;
		rows = '{'{14'h07A0, 0, 1, 0, 0, 1, 1, 0, 0}, '{14'h0721, 0, 1, 0, 0, 1, 0, 1, 0},
			'{14'h01A2, 0, 1, 0, 0, 1, 1, 0, 0}, '{14'h09FF, 0, 1, 0, 0, 1, 1, 0, 0},
			'{14'h0100, 0, 1, 0, 0, 0, 0, 1, 0}, '{14'h0103, 0, 1, 0, 0, 0, 0, 1, 0},
			'{14'h0780, 1, 1, 0, 1, 1, 1, 0, 0}, '{14'h0781, 1, 1, 0, 0, 1, 1, 0, 0},
			'{14'h0781, 2, 1, 0, 1, 1, 1, 0, 0},
			'{OP_SKIP_CLR | 14'h03A3, 0, 1, 1, 0, 1, 0, 0, 1},
			'{OP_SKIP_SET | 14'h0124, 0, 1, 1, 0, 1, 0, 0, 1},
			'{OP_DEC_SKIP | 14'h00A5, 0, 1, 1, 0, 1, 1, 0, 0},
			'{OP_INC_SKIP | 14'h0026, 0, 1, 1, 0, 1, 0, 1, 0},
			'{OP_DEC_SKIP | 14'h0080, 1, 1, 1, 1, 1, 1, 0, 0},
			'{OP_ABS_JUMP | 14'h07FF, 0, 1, 1, 0, 0, 0, 2, 2},
			'{OP_CALL | 14'h0123, 0, 1, 1, 0, 0, 0, 2, 2},
			'{OP_RET_LIT | 14'h005A, 0, 1, 1, 0, 0, 0, 1, 2},
			'{OP_REL_JUMP | 14'h01FF, 0, 1, 1, 0, 0, 0, 2, 2},
			'{OP_RETURN, 0, 1, 1, 0, 0, 0, 2, 3}, '{OP_RET_IRQ, 0, 1, 1, 0, 0, 0, 2, 3},
			'{OP_CALL_ACC, 0, 1, 1, 0, 0, 0, 2, 3}, '{OP_JUMP_ACC, 0, 1, 1, 0, 0, 0, 2, 3},
			'{14'h07A7, 0, 0, 0, 0, 0, 0, 0, 3}, '{NOP_WORD, 0, 1, 0, 0, 0, 0, 0, 3}};
		do_reset();
		foreach (rows[i]) begin
			run_word(rows[i]);
			$display("row %0d done", i);
		end
		for (int m = 0; m < 4; m++) begin
			run_word('{OP_PTR_STEP | 14'h0004 | 14'(m), 0, 1, 0, 0, 2, 2, 2, 3});
			chk(ptr_sel === 1'b1, "step pointer");
			chk(last_ph === (m < 2 ? PH_FIRST : PH_LAST), "step phase");
			chk(last_inc === (m[0] == 1'b0) && last_dec === m[0], "step dir");
			$display("step mode %0d done", m);
		end
		run_word('{14'h3F41, 2, 1, 0, 1, 0, 0, 1, 3});
		chk(ptr_sel === 1'b1, "offset pointer");
		run_word('{14'h3FC1, 0, 1, 0, 0, 0, 0, 0, 3});
		chk(ptr_sel === 1'b1, "offset pointer");
		$display("offset form test done");
		@(posedge clock_in);
		#1;
		prog_word = OP_ABS_JUMP;
		wait_take();
		@(posedge clock_in);
		#1;
		prog_word = NOP_WORD;
		repeat (2) @(posedge clock_in);
		do_reset();
		run_word(rows[1]);
		$display("mid-run reset done");
		end_sim();
	end
endmodule
`default_nettype wire
